// ==== core/flag_bank.sv ====
// Bank of sticky request flags, set by pulses and cleared by written zeros
`timescale 1ns/100ps
module flag_bank #(
	parameter int WIDTH = 8
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [WIDTH-1:0] set_pulse,
	input wire logic clear_write,
	input wire logic [WIDTH-1:0] clear_data,
	output logic [WIDTH-1:0] flags
);
	import irq_flags_pkg::*;

	initial begin
		if (WIDTH < 1 || WIDTH > 8) $error("flag_bank WIDTH must be 1 to 8");
	end

	// Whole state of the bank
	typedef struct packed {
		logic [WIDTH-1:0] flags;
	} bank_s;

	bank_s state;
	bank_s next_state;

	// Written zero clears, written one keeps, a set in the same cycle wins
	always_comb begin
		next_state = state;
		if (clear_write) begin
			next_state.flags = state.flags & clear_data;
		end
		next_state.flags = next_state.flags | set_pulse;
	end

	// State register
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign flags = state.flags;

	// A set pulse always leaves its flag high
	set_wins_a: assert property (@(posedge clk) disable iff (!rstn)
		(set_pulse != '0) |=> ((flags & $past(set_pulse)) == $past(set_pulse)))
		else $error("set pulse lost");
	// Writing ones never clears a flag
	one_keeps_a: assert property (@(posedge clk) disable iff (!rstn)
		clear_write |=> ((flags & $past(flags & clear_data)) == $past(flags & clear_data)))
		else $error("written one cleared a flag");
endmodule

// ==== core/timer_interrupt_flags.sv ====
// Interrupt enable and request flag registers for the timers and other sources
//
// Design decision made here: the plain strobed port.
`timescale 1ns/100ps
module timer_interrupt_flags (
	input wire logic clk,
	input wire logic rstn,
	input irq_flags_pkg::bus_req_s bus,
	output logic [7:0] rdata,
	input irq_flags_pkg::src_pulse_s src,
	input wire logic overflow_timer_wrap,
	input wire logic updown_timer_wrap,
	output logic [7:0] cpu_req_first,
	output logic [7:0] cpu_req_second,
	output logic irq
);
	import irq_flags_pkg::*;

	// Register state of the block apart from the request flag banks
	typedef struct packed {
		logic [7:0] irq_enable_first;
		logic [7:0] irq_enable_second;
		logic [EVT_COUNT-1:0] status;
		logic [EVT_COUNT-1:0] status_enable;
		logic [7:0] rdata;
		logic [7:0] req_first_d;
		logic [7:0] req_second_d;
	} regs_s;

	regs_s state;
	regs_s next_state;

	// Flag bank outputs
	logic [7:0] irq_request_first;
	logic [7:0] irq_request_second;
	// Combined set pulses
	logic [7:0] set_first;
	logic [7:0] set_second;
	// Decoded write strobes
	logic wr_req_first;
	logic wr_req_second;
	// Events that feed the summary status
	logic [EVT_COUNT-1:0] events;

	// Address match helper, used for every write decode
	function automatic logic hit(input bus_req_s b, input logic [15:0] a);
		return b.addr == a;
	endfunction

	// Wrap pulses land on bit 7 of each request bank
	always_comb begin
		set_first = src.first;
		set_first[OVERFLOW_TIMER_IRQ_FLAG_BIT] = src.first[OVERFLOW_TIMER_IRQ_FLAG_BIT]
			| overflow_timer_wrap;
		set_second = src.second;
		set_second[UPDOWN_TIMER_IRQ_FLAG_BIT] = src.second[UPDOWN_TIMER_IRQ_FLAG_BIT]
			| updown_timer_wrap;
	end

	assign wr_req_first = bus.wr && hit(bus, REQUEST_FIRST_ADDR);
	assign wr_req_second = bus.wr && hit(bus, REQUEST_SECOND_ADDR);

	// First request bank
	flag_bank #(.WIDTH(8)) first_bank (
		.clk(clk),
		.rstn(rstn),
		.set_pulse(set_first),
		.clear_write(wr_req_first),
		.clear_data(bus.wdata),
		.flags(irq_request_first)
	);

	// Second request bank
	flag_bank #(.WIDTH(8)) second_bank (
		.clk(clk),
		.rstn(rstn),
		.set_pulse(set_second),
		.clear_write(wr_req_second),
		.clear_data(bus.wdata),
		.flags(irq_request_second)
	);

	// Rising requests become summary events
	always_comb begin
		events = '0;
		events[EVT_OVERFLOW_TIMER] = cpu_req_first[OVERFLOW_TIMER_IRQ_FLAG_BIT]
			& ~state.req_first_d[OVERFLOW_TIMER_IRQ_FLAG_BIT];
		events[EVT_UPDOWN_TIMER] = cpu_req_second[UPDOWN_TIMER_IRQ_FLAG_BIT]
			& ~state.req_second_d[UPDOWN_TIMER_IRQ_FLAG_BIT];
		events[EVT_OTHER_FIRST] = |(cpu_req_first & ~state.req_first_d);
		events[EVT_OTHER_SECOND] = |(cpu_req_second & ~state.req_second_d);
	end

	// Register writes, read mux and sticky status
	always_comb begin
		next_state = state;
		next_state.req_first_d = cpu_req_first;
		next_state.req_second_d = cpu_req_second;
		// Enable registers are plain storage
		if (bus.wr && hit(bus, ENABLE_FIRST_ADDR)) begin
			next_state.irq_enable_first = bus.wdata;
		end
		if (bus.wr && hit(bus, ENABLE_SECOND_ADDR)) begin
			next_state.irq_enable_second = bus.wdata;
		end
		if (bus.wr && hit(bus, IRQ_ENABLE_ADDR)) begin
			next_state.status_enable = bus.wdata[EVT_COUNT-1:0];
		end
		// Clear by writing ones; a same-cycle event still sets
		if (bus.wr && hit(bus, IRQ_CLEAR_ADDR)) begin
			next_state.status = state.status & ~bus.wdata[EVT_COUNT-1:0];
		end
		next_state.status = next_state.status | events;
		// Read data stand for one cycle after the strobe, else zero
		next_state.rdata = READ_ZERO;
		if (bus.rd) begin
			case (bus.addr)
				ENABLE_FIRST_ADDR: next_state.rdata = state.irq_enable_first;
				ENABLE_SECOND_ADDR: next_state.rdata = state.irq_enable_second;
				REQUEST_FIRST_ADDR: next_state.rdata = irq_request_first;
				REQUEST_SECOND_ADDR: next_state.rdata = irq_request_second;
				IRQ_STATUS_ADDR: next_state.rdata = {{(8-EVT_COUNT){1'b0}}, state.status};
				IRQ_ENABLE_ADDR: next_state.rdata = {{(8-EVT_COUNT){1'b0}}, state.status_enable};
				default: next_state.rdata = READ_ZERO; // Unmapped and clear register read zero
			endcase
		end
	end

	// State register
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state.irq_enable_first <= ENABLE_RESET;
			state.irq_enable_second <= ENABLE_RESET;
			state.status <= '0;
			state.status_enable <= '0;
			state.rdata <= READ_ZERO;
			state.req_first_d <= REQUEST_RESET;
			state.req_second_d <= REQUEST_RESET;
		end else begin
			state <= next_state;
		end
	end

	// Requests reach the CPU only where flag and enable agree; the timer flag at bit 7 is gated by
	// enable bit 5 (first) or 1 (second), which pass no request of their own; other bits use the same position
	always_comb begin
		cpu_req_first = irq_request_first & state.irq_enable_first;
		cpu_req_first[OVERFLOW_TIMER_IRQ_FLAG_BIT] = irq_request_first[OVERFLOW_TIMER_IRQ_FLAG_BIT]
			& state.irq_enable_first[OVERFLOW_TIMER_IRQ_ENABLE_BIT];
		cpu_req_first[OVERFLOW_TIMER_IRQ_ENABLE_BIT] = 1'b0;
		cpu_req_second = irq_request_second & state.irq_enable_second;
		cpu_req_second[UPDOWN_TIMER_IRQ_FLAG_BIT] = irq_request_second[UPDOWN_TIMER_IRQ_FLAG_BIT]
			& state.irq_enable_second[UPDOWN_TIMER_IRQ_ENABLE_BIT];
		cpu_req_second[UPDOWN_TIMER_IRQ_ENABLE_BIT] = 1'b0;
	end

	assign rdata = state.rdata;
	assign irq = |(state.status & state.status_enable);

	// Overflow wrap raises its flag next cycle
	ovf_wrap_a: assert property (@(posedge clk) disable iff (!rstn)
		overflow_timer_wrap |=> irq_request_first[OVERFLOW_TIMER_IRQ_FLAG_BIT])
		else $error("overflow wrap did not set flag");
	// Up/down wrap raises its flag next cycle
	updown_wrap_a: assert property (@(posedge clk) disable iff (!rstn)
		updown_timer_wrap |=> irq_request_second[UPDOWN_TIMER_IRQ_FLAG_BIT])
		else $error("up/down wrap did not set flag");
	// Zero write without a set clears the overflow flag
	ovf_clear_a: assert property (@(posedge clk) disable iff (!rstn)
		(wr_req_first && !bus.wdata[7] && !set_first[7]) |=> !irq_request_first[7])
		else $error("overflow flag not cleared");
	// Zero write without a set clears the up/down flag
	updown_clear_a: assert property (@(posedge clk) disable iff (!rstn)
		(wr_req_second && !bus.wdata[7] && !set_second[7]) |=> !irq_request_second[7])
		else $error("up/down flag not cleared");
	// Overflow request follows flag and enable
	ovf_gate_a: assert property (@(posedge clk) disable iff (!rstn)
		cpu_req_first[7] == (irq_request_first[7] && state.irq_enable_first[5]))
		else $error("overflow request gating wrong");
	// Up/down request follows flag and enable
	updown_gate_a: assert property (@(posedge clk) disable iff (!rstn)
		cpu_req_second[7] == (irq_request_second[7] && state.irq_enable_second[1]))
		else $error("up/down request gating wrong");
	// First bank source in bit 0 latches its pulse
	src_latch_a: assert property (@(posedge clk) disable iff (!rstn)
		src.first[0] |=> irq_request_first[0])
		else $error("first bank source lost");
	// Second bank source in bit 0 latches its pulse
	src2_latch_a: assert property (@(posedge clk) disable iff (!rstn)
		src.second[0] |=> irq_request_second[0])
		else $error("second bank source lost");
	// Writing one holds a set flag
	one_holds_a: assert property (@(posedge clk) disable iff (!rstn)
		(wr_req_first && bus.wdata[7] && irq_request_first[7]) |=> irq_request_first[7])
		else $error("writing one cleared flag");
	cover_ovf_c: cover property (@(posedge clk) disable iff (!rstn) cpu_req_first[7]);
	cover_updown_c: cover property (@(posedge clk) disable iff (!rstn) cpu_req_second[7]);
	cover_irq_c: cover property (@(posedge clk) disable iff (!rstn) irq);
endmodule

// ==== inc/irq_flags_pkg.sv ====
// Package of offsets, bit positions and carriers for the timer interrupt flag block
package irq_flags_pkg;
	// Register offsets (byte addresses in the 16-bit space)
	localparam logic [15:0] ENABLE_FIRST_ADDR = 16'hFFF3;
	localparam logic [15:0] ENABLE_SECOND_ADDR = 16'hFFF4;
	localparam logic [15:0] REQUEST_FIRST_ADDR = 16'hFFF6;
	localparam logic [15:0] REQUEST_SECOND_ADDR = 16'hFFF7;
	localparam logic [15:0] IRQ_STATUS_ADDR = 16'hFFF8;
	localparam logic [15:0] IRQ_CLEAR_ADDR = 16'hFFF9;
	localparam logic [15:0] IRQ_ENABLE_ADDR = 16'hFFFA;
	// Field positions
	localparam int OVERFLOW_TIMER_IRQ_ENABLE_BIT = 5;
	localparam int OVERFLOW_TIMER_IRQ_FLAG_BIT = 7;
	localparam int UPDOWN_TIMER_IRQ_ENABLE_BIT = 1;
	localparam int UPDOWN_TIMER_IRQ_FLAG_BIT = 7;
	// Reset values
	localparam logic [7:0] ENABLE_RESET = 8'h00;
	localparam logic [7:0] REQUEST_RESET = 8'h00;
	localparam logic [7:0] READ_ZERO = 8'h00;
	// Summary status bit positions
	localparam int EVT_OVERFLOW_TIMER = 0;
	localparam int EVT_UPDOWN_TIMER = 1;
	localparam int EVT_OTHER_FIRST = 2;
	localparam int EVT_OTHER_SECOND = 3;
	localparam int EVT_COUNT = 4;

	// Register bus request
	typedef struct packed {
		logic [15:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} bus_req_s;

	// Request pulses from the timers and other sources
	typedef struct packed {
		logic [7:0] first;
		logic [7:0] second;
	} src_pulse_s;
endpackage

// ==== verif/tb_top.sv ====
// Self-checking bench for the timer interrupt flag block
`timescale 1ns/100ps
module tb_top;
	import irq_flags_pkg::*;
	// Stimulus and observed signals
	logic clk;
	logic rstn;
	bus_req_s bus;
	src_pulse_s src;
	logic run_a;
	logic run_c;
	logic down;
	logic [7:0] rdata;
	logic [7:0] cpu_req_first;
	logic [7:0] cpu_req_second;
	logic irq;
	logic overflow_timer_wrap;
	logic updown_timer_wrap;
	int bad_count = 0;
	int compares = 0;
	// Bus with both strobes low
	localparam bus_req_s idle_req = '0;

	timer_interrupt_flags dut (.clk(clk), .rstn(rstn), .bus(bus), .rdata(rdata), .src(src),
		.overflow_timer_wrap(overflow_timer_wrap), .updown_timer_wrap(updown_timer_wrap),
		.cpu_req_first(cpu_req_first), .cpu_req_second(cpu_req_second), .irq(irq));
	timer_model timers (.clk(clk), .rstn(rstn), .run_a(run_a), .run_c(run_c), .down(down),
		.overflow_timer_wrap(overflow_timer_wrap), .updown_timer_wrap(updown_timer_wrap));

	// Free-running 100 MHz clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// Byte compare; case inequality so an unknown never matches
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// One-cycle write; returns just after the edge that took it
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		bus <= {a, d, 1'b1, 1'b0};
		@(posedge clk);
		bus <= idle_req;
		#1;
	endtask

	// One-cycle read; data stand only in the following cycle
	task automatic rd(input logic [15:0] a, input logic [7:0] exp);
		@(posedge clk);
		bus <= {a, 8'h00, 1'b0, 1'b1};
		@(posedge clk);
		bus <= idle_req;
		#1;
		chk(rdata, exp);
	endtask

	// Bounded wait for a wrap pulse of the chosen timer
	task automatic wait_wrap(input bit sel);
		int i;
		for (i = 0; i < 300; i++) begin
			@(posedge clk);
			#1;
			if ((sel ? updown_timer_wrap : overflow_timer_wrap) === 1'b1) begin
				break;
			end
		end
		chk({7'h00, i < 300}, 8'h01);
	endtask

	// Registers come out of reset cleared, no request, no interrupt
	task automatic t_reset();
		rd(ENABLE_FIRST_ADDR, ENABLE_RESET);
		rd(ENABLE_SECOND_ADDR, ENABLE_RESET);
		rd(REQUEST_FIRST_ADDR, REQUEST_RESET);
		rd(REQUEST_SECOND_ADDR, REQUEST_RESET);
		chk({7'h00, irq}, 8'h00);
	endtask

	// Overflow timer wraps; enable gates it; ones keep, zero clears
	task automatic t_timer_a();
		@(posedge clk);
		run_a <= 1'b1;
		wait_wrap(1'b0);
		@(posedge clk);
		run_a <= 1'b0;
		rd(REQUEST_FIRST_ADDR, 8'h80);
		chk(cpu_req_first, 8'h00);
		wr(ENABLE_FIRST_ADDR, 8'h20);
		chk(cpu_req_first, 8'h80);
		wr(REQUEST_FIRST_ADDR, 8'hFF);
		rd(REQUEST_FIRST_ADDR, 8'h80);
		wr(REQUEST_FIRST_ADDR, 8'h7F);
		rd(REQUEST_FIRST_ADDR, 8'h00);
		chk(cpu_req_first, 8'h00);
	endtask

	// Up/down timer: a wrap counting up, then one counting down
	task automatic t_updown();
		wr(ENABLE_SECOND_ADDR, 8'h02);
		for (int d = 0; d < 2; d++) begin
			@(posedge clk);
			down <= d[0];
			run_c <= 1'b1;
			wait_wrap(1'b1);
			@(posedge clk);
			run_c <= 1'b0;
			rd(REQUEST_SECOND_ADDR, 8'h80);
			chk(cpu_req_second, 8'h80);
			wr(REQUEST_SECOND_ADDR, 8'h7F);
			rd(REQUEST_SECOND_ADDR, 8'h00);
		end
	endtask

	// Each other source of both banks, with all enables set
	task automatic t_sources();
		logic [7:0] b;
		wr(ENABLE_FIRST_ADDR, 8'hFF);
		wr(ENABLE_SECOND_ADDR, 8'hFF);
		for (int j = 0; j < 2; j++) begin
			for (int i = 0; i < 7; i++) begin
				b = 8'h01 << i;
				@(posedge clk);
				src <= j ? {8'h00, b} : {b, 8'h00};
				@(posedge clk);
				src <= '0;
				#1;
				// Bits that hold a timer enable never pass a source of their own
				chk(j ? cpu_req_second : cpu_req_first, (i == (j ? 1 : 5)) ? 8'h00 : b);
				rd(j ? REQUEST_SECOND_ADDR : REQUEST_FIRST_ADDR, b);
				wr(j ? REQUEST_SECOND_ADDR : REQUEST_FIRST_ADDR, ~b);
			end
		end
	endtask

	// Sticky status, masked, then raised and cleared; unmapped read
	task automatic t_irq();
		rd(IRQ_STATUS_ADDR, 8'h0F);
		chk({7'h00, irq}, 8'h00);
		wr(IRQ_ENABLE_ADDR, 8'h02);
		chk({7'h00, irq}, 8'h01);
		rd(IRQ_ENABLE_ADDR, 8'h02);
		wr(IRQ_CLEAR_ADDR, 8'h02);
		chk({7'h00, irq}, 8'h00);
		rd(IRQ_STATUS_ADDR, 8'h0D);
		rd(16'hFFF0, READ_ZERO);
	endtask

	// Counts, verdict and end of run
	task automatic conclude();
		$display("mismatches %0d comparisons %0d", bad_count, compares);
		if (bad_count == 0 && compares > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// Main sequence: reset held for 16 cycles, then the scenarios
	initial begin
		rstn = 1'b0;
		bus = idle_req;
		src = '0;
		run_a = 1'b0;
		run_c = 1'b0;
		down = 1'b0;
		repeat (16) @(posedge clk);
		rstn <= 1'b1;
		t_reset();
		t_timer_a();
		t_updown();
		t_sources();
		t_irq();
		conclude();
	end

	// Watchdog: the tests need about 700 cycles, so 10000 means a hang
	initial begin
		#100000;
		bad_count++;
		conclude();
	end
endmodule

// ==== verif/timer_model.sv ====
// Model of the two timers that feed wrap pulses into the flag block
`timescale 1ns/100ps
module timer_model (
	input wire logic clk,
	input wire logic rstn,
	input wire logic run_a,
	input wire logic run_c,
	input wire logic down,
	output logic overflow_timer_wrap,
	output logic updown_timer_wrap
);
	// Eight-bit counts of the overflow timer and the up/down timer
	logic [7:0] cnt_a;
	logic [7:0] cnt_c;

	// Counters step only while run is high, so wraps come only when the bench asks
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cnt_a <= 8'h00;
			cnt_c <= 8'h00;
			overflow_timer_wrap <= 1'b0;
			updown_timer_wrap <= 1'b0;
		end else begin
			// One-cycle pulse on the step from all ones to zero
			overflow_timer_wrap <= run_a && cnt_a == 8'hFF;
			// Either direction counts: up past all ones, down past zero
			updown_timer_wrap <= run_c && (down ? cnt_c == 8'h00 : cnt_c == 8'hFF);
			if (run_a) begin
				cnt_a <= cnt_a + 8'h01;
			end
			if (run_c) begin
				cnt_c <= down ? cnt_c - 8'h01 : cnt_c + 8'h01;
			end
		end
	end
endmodule
